// file: logic/addressing_mode_decoder.sv
// Behaviour
// - Inherent form: opcode only, no operands
// - Immediate form: opcode plus operand byte
// - Short direct: one address byte, page zero
// - Long direct: two-byte address, full space
// - Indexed address is unsigned index plus offset
// - No-offset indexed: index register alone addresses
// - Second-index no-offset form one byte longer
// - Short indexed sum reaches 1FE unwrapped
// - Long indexed adds word offset, full space
// - Indirect: operand byte locates the pointer
// - Short indirect: byte pointer, page zero
// - Long indirect: word pointer from page zero
// - Relative: signed displacement plus next PC
// - Short direct and indirect forms page zero, long forms everywhere
// - Read-modify-write ops take short forms only
// - Inherent form covers control and register ops
// - Immediate only for load, compare, logic, arithmetic
// - Index-swap prefix selects second index register
// - Indirection prefix turns forms into indirect
module addressing_mode_decoder
    import amd_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Fetch side
    input  wire logic              fetchValid,
    input  wire logic [7:0]        fetchByte,
    input  wire logic [ADDR_W-1:0] fetchPc,
    output logic                   fetchReq,
    output logic [ADDR_W-1:0]      fetchAddr,
    // Index registers from the datapath
    input  wire logic [7:0]        indexFirst,
    input  wire logic [7:0]        indexSecond,
    // Execution side
    input  wire logic              execReady,
    output logic                   decodeValid,
    output logic [7:0]             opcodeOut,
    output form_t                  formOut,
    output logic [ADDR_W-1:0]      effAddr,
    output logic [7:0]             immValue,
    output logic [2:0]             instrLength,
    output logic                   secondIndexUsed,
    output logic                   readModifyWrite,
    output logic                   illegalOpcode
);

    // ==================================================================
    // State
    fetch_t            state;
    logic [7:0]        opcode;
    logic              swapPending;
    logic              indPending;
    logic [2:0]        prefixCount;
    logic [7:0]        oper1;
    logic [7:0]        oper2;
    logic [7:0]        ptrHi;
    logic [ADDR_W-1:0] nextPc;

    decode_bus_if dec ();

    assign dec.opcode    = opcode;
    assign dec.indirect  = indPending;
    assign dec.useSecond = swapPending;

    form_table u_table (
        .dec (dec)
    );

    function automatic logic [ADDR_W-1:0] pageZero(input logic [7:0] b);
        pageZero = {8'h00, b};
    endfunction

    function automatic logic [ADDR_W-1:0] indexSum(input logic [7:0] idx, input logic [15:0] off);
        indexSum = {8'h00, idx} + off;
    endfunction

    logic [7:0] indexSel;
    assign indexSel = swapPending ? indexSecond : indexFirst;

    // ==================================================================
    // Fetch sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state       <= ST_OPCODE;
            opcode      <= 8'h00;
            swapPending <= 1'b0;
            indPending  <= 1'b0;
            prefixCount <= 3'd0;
            oper1       <= 8'h00;
            oper2       <= 8'h00;
            ptrHi       <= 8'h00;
            nextPc      <= '0;
        end else begin
            case (state)
                ST_OPCODE: begin
                    if (fetchValid) begin
                        if (fetchByte == INDEX_SWAP_PREFIX) begin
                            swapPending <= 1'b1;
                            prefixCount <= prefixCount + 3'd1;
                        end else if (fetchByte == INDIRECTION_PREFIX) begin
                            indPending  <= 1'b1;
                            prefixCount <= prefixCount + 3'd1;
                        end else begin
                            opcode <= fetchByte;
                            state  <= ST_OPER1;
                        end
                    end
                end
                ST_OPER1: begin
                    // Table output is valid now that the opcode is held
                    if (dec.operandBytes == 3'd0) begin
                        nextPc <= fetchPc;
                        state  <= ST_DONE;
                    end else if (fetchValid) begin
                        oper1     <= fetchByte;
                        if (dec.operandBytes == 3'd2) begin
                            state <= ST_OPER2;
                        end else if (indPending) begin
                            state <= ST_PTR_HI;
                        end else begin
                            nextPc <= fetchPc + 16'd1;
                            state  <= ST_DONE;
                        end
                    end
                end
                ST_OPER2: begin
                    if (fetchValid) begin
                        oper2  <= fetchByte;
                        nextPc <= fetchPc + 16'd1;
                        state  <= (indPending && dec.form == FORM_BIT_REL) ? ST_PTR_HI : ST_DONE;
                    end
                end
                ST_PTR_HI: begin
                    // First pointer byte: whole pointer for byte-sized pointers
                    if (fetchValid) begin
                        ptrHi  <= fetchByte;
                        nextPc <= fetchPc;
                        if (dec.form == FORM_IND_LONG || dec.form == FORM_IIX_LONG) begin
                            state <= ST_PTR_LO;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_PTR_LO: begin
                    if (fetchValid) begin
                        oper2 <= fetchByte;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (execReady) begin
                        swapPending <= 1'b0;
                        indPending  <= 1'b0;
                        prefixCount <= 3'd0;
                        state       <= ST_OPCODE;
                    end
                end
                default: state <= ST_OPCODE;
            endcase
        end
    end

    // ==================================================================
    // Memory address request for operand and pointer bytes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetchReq  <= 1'b0;
            fetchAddr <= '0;
        end else begin
            // Ask only when the next state takes a byte, so the fetch side
            // never steps past a byte that nobody consumes
            case (state)
                ST_OPCODE: fetchReq <= !(fetchValid && fetchByte != INDEX_SWAP_PREFIX
                                         && fetchByte != INDIRECTION_PREFIX);
                ST_OPER1:  fetchReq <= !(dec.operandBytes == 3'd0
                                         || (fetchValid && dec.operandBytes == 3'd1 && !indPending));
                ST_OPER2:  fetchReq <= !(fetchValid && !(indPending && dec.form == FORM_BIT_REL));
                ST_PTR_HI: fetchReq <= !(fetchValid && dec.form != FORM_IND_LONG && dec.form != FORM_IIX_LONG);
                ST_PTR_LO: fetchReq <= !fetchValid;
                ST_DONE:   fetchReq <= execReady;
                default:   fetchReq <= 1'b0;
            endcase
            if (state == ST_OPER1 && fetchValid && indPending && dec.operandBytes == 3'd1) begin
                fetchAddr <= pageZero(fetchByte);
            end else if (state == ST_PTR_HI && fetchValid) begin
                fetchAddr <= pageZero(oper1 + 8'd1);
            end else if (state != ST_PTR_HI && state != ST_PTR_LO) begin
                // Pointer address stays put through wait states
                fetchAddr <= fetchPc;
            end
        end
    end

    // ==================================================================
    // Effective address
    logic [ADDR_W-1:0] next_effAddr;
    logic [15:0]       relTarget;

    // Pc already points past the branch when displacement is applied
    assign relTarget = nextPc + {{8{oper1[7]}}, oper1};

    always_comb begin
        case (formOut)
            FORM_DIR_SHORT, FORM_BIT_DIRECT, FORM_BIT_REL: next_effAddr = pageZero(oper1);
            FORM_DIR_LONG:   next_effAddr = {oper1, oper2};
            FORM_IDX_NONE:   next_effAddr = pageZero(indexSel);
            FORM_IDX_SHORT:  next_effAddr = indexSum(indexSel, {8'h00, oper1});
            FORM_IDX_LONG:   next_effAddr = indexSum(indexSel, {oper1, oper2});
            FORM_IND_SHORT:  next_effAddr = pageZero(ptrHi);
            FORM_IND_LONG:   next_effAddr = {ptrHi, oper2};
            FORM_IIX_SHORT:  next_effAddr = indexSum(indexSel, {8'h00, ptrHi});
            FORM_IIX_LONG:   next_effAddr = indexSum(indexSel, {ptrHi, oper2});
            FORM_REL_DIRECT: next_effAddr = relTarget;
            FORM_REL_IND:    next_effAddr = nextPc + {{8{ptrHi[7]}}, ptrHi};
            default:         next_effAddr = '0;
        endcase
    end

    // ==================================================================
    // Outputs to the execution datapath, all registered
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            decodeValid     <= 1'b0;
            opcodeOut       <= 8'h00;
            formOut         <= FORM_INHERENT;
            effAddr         <= '0;
            immValue        <= 8'h00;
            instrLength     <= 3'd0;
            secondIndexUsed <= 1'b0;
            readModifyWrite <= 1'b0;
            illegalOpcode   <= 1'b0;
        end else begin
            decodeValid <= (state == ST_DONE) && !execReady;
            if (state != ST_DONE) begin
                opcodeOut       <= opcode;
                formOut         <= dec.form;
                secondIndexUsed <= swapPending;
                readModifyWrite <= dec.readModifyWrite;
                illegalOpcode   <= (dec.form == FORM_ILLEGAL);
                // Prefixes count toward length; the prefix makes no-offset second-index one longer
                instrLength     <= 3'd1 + prefixCount + dec.operandBytes;
            end else begin
                effAddr  <= next_effAddr;
                immValue <= oper1;
            end
        end
    end

endmodule

// file: logic/amd_pkg.sv
package amd_pkg;

    // ==================================================================
    // Prefix bytes
    localparam logic [7:0] INDEX_SWAP_PREFIX  = 8'h90;
    localparam logic [7:0] INDIRECTION_PREFIX = 8'h92;

    // ==================================================================
    // Address space
    localparam int ADDR_W = 16;
    localparam logic [15:0] PAGE_ZERO_TOP = 16'h00FF;

    // ==================================================================
    // Addressing forms, derived from opcode row (high nibble group)
    typedef enum logic [3:0] {
        FORM_INHERENT   = 4'h0,
        FORM_IMMEDIATE  = 4'h1,
        FORM_DIR_SHORT  = 4'h2,
        FORM_DIR_LONG   = 4'h3,
        FORM_IDX_NONE   = 4'h4,
        FORM_IDX_SHORT  = 4'h5,
        FORM_IDX_LONG   = 4'h6,
        FORM_IND_SHORT  = 4'h7,
        FORM_IND_LONG   = 4'h8,
        FORM_IIX_SHORT  = 4'h9,
        FORM_IIX_LONG   = 4'hA,
        FORM_REL_DIRECT = 4'hB,
        FORM_REL_IND    = 4'hC,
        FORM_BIT_DIRECT = 4'hD,
        FORM_BIT_REL    = 4'hE,
        FORM_ILLEGAL    = 4'hF
    } form_t;

    // Opcode high-nibble groups of the core
    localparam logic [3:0] GRP_BIT_REL   = 4'h0;
    localparam logic [3:0] GRP_BIT_DIR   = 4'h1;
    localparam logic [3:0] GRP_REL       = 4'h2;
    localparam logic [3:0] GRP_RMW_DIR   = 4'h3;
    localparam logic [3:0] GRP_RMW_A     = 4'h4;
    localparam logic [3:0] GRP_RMW_X     = 4'h5;
    localparam logic [3:0] GRP_RMW_IXS   = 4'h6;
    localparam logic [3:0] GRP_RMW_IX    = 4'h7;
    localparam logic [3:0] GRP_CTRL      = 4'h8;
    localparam logic [3:0] GRP_CTRL2     = 4'h9;
    localparam logic [3:0] GRP_ALU_IMM   = 4'hA;
    localparam logic [3:0] GRP_ALU_DIR   = 4'hB;
    localparam logic [3:0] GRP_ALU_EXT   = 4'hC;
    localparam logic [3:0] GRP_ALU_IXL   = 4'hD;
    localparam logic [3:0] GRP_ALU_IXS   = 4'hE;
    localparam logic [3:0] GRP_ALU_IX    = 4'hF;

    // Inherent opcodes: control groups plus byte product (group 4)
    localparam logic [7:0] OP_NOP                  = 8'h9D;
    localparam logic [7:0] OP_TRAP                 = 8'h83;
    localparam logic [7:0] OP_SLEEP_UNTIL_IRQ      = 8'h8F;
    localparam logic [7:0] OP_HALT                 = 8'h8E;
    localparam logic [7:0] OP_SUBROUTINE_EXIT      = 8'h81;
    localparam logic [7:0] OP_INTERRUPT_EXIT       = 8'h80;
    localparam logic [7:0] OP_MASK_INTERRUPTS      = 8'h9B;
    localparam logic [7:0] OP_UNMASK_INTERRUPTS    = 8'h9A;
    localparam logic [7:0] OP_CARRY_FORCE_ONE      = 8'h99;
    localparam logic [7:0] OP_CARRY_FORCE_ZERO     = 8'h98;
    localparam logic [7:0] OP_STACK_POINTER_RELOAD = 8'h9C;
    localparam logic [7:0] OP_BYTE_PRODUCT         = 8'h42;

    // ALU low nibbles that have an immediate form
    localparam logic [15:0] IMM_OK_MASK = 16'h0EFF;

    // Fetch sequencer states
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_OPER1  = 3'b001,
        ST_OPER2  = 3'b011,
        ST_PTR_HI = 3'b010,
        ST_PTR_LO = 3'b110,
        ST_DONE   = 3'b111
    } fetch_t;

endpackage

// file: logic/decode_bus_if.sv
interface decode_bus_if;
    import amd_pkg::*;
    logic [7:0] opcode;
    logic       indirect;
    logic       useSecond;
    form_t      form;
    logic [2:0] operandBytes;
    logic       readModifyWrite;
    logic       shortOnly;

    modport table_side (input opcode, input indirect, input useSecond,
                        output form, output operandBytes, output readModifyWrite, output shortOnly);
    modport core_side  (output opcode, output indirect, output useSecond,
                        input form, input operandBytes, input readModifyWrite, input shortOnly);
endinterface

// file: logic/form_table.sv
module form_table
    import amd_pkg::*;
(
    decode_bus_if.table_side dec
);

    function automatic logic isInherentCtrl(input logic [7:0] op);
        case (op)
            OP_NOP, OP_TRAP, OP_SLEEP_UNTIL_IRQ, OP_HALT, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
            OP_MASK_INTERRUPTS, OP_UNMASK_INTERRUPTS, OP_CARRY_FORCE_ONE, OP_CARRY_FORCE_ZERO,
            OP_STACK_POINTER_RELOAD, OP_BYTE_PRODUCT: isInherentCtrl = 1'b1;
            default: isInherentCtrl = 1'b0;
        endcase
    endfunction

    always_comb begin
        form_t f;
        logic  rmw;
        f   = FORM_ILLEGAL;
        rmw = 1'b0;
        case (dec.opcode[7:4])
            GRP_BIT_REL: begin
                f = FORM_BIT_REL;
                rmw = 1'b1;
            end
            GRP_BIT_DIR: begin
                f = FORM_BIT_DIRECT;
                rmw = 1'b1;
            end
            GRP_REL: f = dec.indirect ? FORM_REL_IND : FORM_REL_DIRECT;
            GRP_RMW_DIR: begin
                f = dec.indirect ? FORM_IND_SHORT : FORM_DIR_SHORT;
                rmw = 1'b1;
            end
            GRP_RMW_A, GRP_RMW_X: f = FORM_INHERENT;
            GRP_RMW_IXS: begin
                f = dec.indirect ? FORM_IIX_SHORT : FORM_IDX_SHORT;
                rmw = 1'b1;
            end
            GRP_RMW_IX: begin
                f = FORM_IDX_NONE;
                rmw = 1'b1;
            end
            GRP_CTRL, GRP_CTRL2: f = isInherentCtrl(dec.opcode) ? FORM_INHERENT : FORM_ILLEGAL;
            GRP_ALU_IMM: f = IMM_OK_MASK[dec.opcode[3:0]] ? FORM_IMMEDIATE : FORM_ILLEGAL;
            GRP_ALU_DIR: f = dec.indirect ? FORM_IND_SHORT : FORM_DIR_SHORT;
            GRP_ALU_EXT: f = dec.indirect ? FORM_IND_LONG : FORM_DIR_LONG;
            GRP_ALU_IXL: f = dec.indirect ? FORM_IIX_LONG : FORM_IDX_LONG;
            GRP_ALU_IXS: f = dec.indirect ? FORM_IIX_SHORT : FORM_IDX_SHORT;
            GRP_ALU_IX:  f = FORM_IDX_NONE;
            default: f = FORM_ILLEGAL;
        endcase
        dec.form            = f;
        dec.readModifyWrite = rmw;
        dec.shortOnly       = rmw;
        case (f)
            FORM_INHERENT, FORM_IDX_NONE, FORM_ILLEGAL: dec.operandBytes = 3'd0;
            FORM_DIR_LONG, FORM_IDX_LONG, FORM_BIT_REL:  dec.operandBytes = 3'd2;
            FORM_REL_IND:                                dec.operandBytes = 3'd1;
            default:                                     dec.operandBytes = 3'd1;
        endcase
    end

endmodule

// file: verif/addressing_mode_decoder_assertions.sv
module addressing_mode_decoder_assertions
    import amd_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // Observed ports
    input wire logic              fetchReq,
    input wire logic [7:0]        indexFirst,
    input wire logic [7:0]        indexSecond,
    input wire logic              execReady,
    input wire logic              decodeValid,
    input form_t                  formOut,
    input wire logic [ADDR_W-1:0] effAddr,
    input wire logic [2:0]        instrLength,
    input wire logic              secondIndexUsed,
    input wire logic              readModifyWrite
);
    logic [15:0] selIndex;
    logic [2:0]  swapAdd;

    assign selIndex = {8'h00, secondIndexUsed ? indexSecond : indexFirst};
    assign swapAdd  = secondIndexUsed ? 3'h1 : 3'h0;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // =============================================================
    // Properties
    a_valid_stands: assert property (
        decodeValid && !execReady |=> decodeValid && $stable(effAddr) && $stable(instrLength) && $stable(formOut))
        else $error("decoded result changed before acceptance");
    a_no_fetch_valid: assert property (decodeValid |-> !fetchReq)
        else $error("fetch requested while result stands");
    a_inherent_one: assert property (
        decodeValid && formOut == FORM_INHERENT && !secondIndexUsed |-> instrLength == 3'h1)
        else $error("inherent length wrong");
    a_imm_two: assert property (decodeValid && formOut == FORM_IMMEDIATE |-> instrLength == 3'h2 + swapAdd)
        else $error("immediate length wrong");
    a_short_direct: assert property (
        decodeValid && formOut == FORM_DIR_SHORT |-> effAddr[15:8] == 8'h00 && instrLength == 3'h2 + swapAdd)
        else $error("short direct wrong");
    a_long_direct: assert property (decodeValid && formOut == FORM_DIR_LONG |-> instrLength == 3'h3 + swapAdd)
        else $error("long direct length wrong");
    a_noofs_index: assert property (
        decodeValid && formOut == FORM_IDX_NONE |-> effAddr == selIndex && instrLength == 3'h1 + swapAdd)
        else $error("no-offset indexed wrong");
    a_short_index: assert property (
        decodeValid && formOut == FORM_IDX_SHORT |-> (effAddr - selIndex) <= 16'h00FF)
        else $error("short indexed sum wrong");
    a_short_indirect: assert property (
        decodeValid && formOut == FORM_IND_SHORT |-> effAddr[15:8] == 8'h00 && instrLength == 3'h3)
        else $error("short indirect wrong");
    a_rel_length: assert property (decodeValid && formOut == FORM_REL_DIRECT |-> instrLength == 3'h2)
        else $error("relative length wrong");
    a_rmw_short: assert property (decodeValid && readModifyWrite |-> formOut inside {FORM_INHERENT,
        FORM_DIR_SHORT, FORM_IDX_NONE, FORM_IDX_SHORT, FORM_IND_SHORT, FORM_IIX_SHORT, FORM_BIT_DIRECT, FORM_BIT_REL})
        else $error("memory update with long form");

    c_long_ind: cover property (decodeValid && formOut == FORM_IND_LONG);
    c_second: cover property (decodeValid && formOut == FORM_IDX_NONE && secondIndexUsed);
    c_rmw: cover property (decodeValid && readModifyWrite);
endmodule

bind addressing_mode_decoder addressing_mode_decoder_assertions chk_u (.core_clk(core_clk), .rst(rst),
    .fetchReq(fetchReq), .indexFirst(indexFirst), .indexSecond(indexSecond), .execReady(execReady),
    .decodeValid(decodeValid), .formOut(formOut), .effAddr(effAddr), .instrLength(instrLength),
    .secondIndexUsed(secondIndexUsed), .readModifyWrite(readModifyWrite));

// file: verif/fetch_memory_model.sv
module fetch_memory_model
    import amd_pkg::*;
#(
    parameter logic [15:0] START_PC = 16'h8000
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Test control
    input  wire logic        hold,
    input  wire logic        slow,
    // Fetch path
    input  wire logic        fetchReq,
    input  wire logic [15:0] fetchAddr,
    output logic             fetchValid,
    output logic [7:0]       fetchByte,
    output logic [15:0]      fetchPc
);
    logic [7:0]  mem [0:65535];
    logic [15:0] pc;
    logic        phase;
    logic        ptrFetch;

    // Pointers live in page zero, program well above it
    assign ptrFetch = fetchAddr[15:8] == 8'h00 && fetchAddr != 16'h0000;
    assign fetchPc  = pc;

    always_ff @(negedge core_clk or posedge rst) begin
        if (rst) begin
            fetchValid <= 1'b0;
            fetchByte  <= 8'h00;
            phase      <= 1'b0;
        end else begin
            phase <= ~phase;
            if (fetchReq && !hold && !(slow && phase)) begin
                fetchValid <= 1'b1;
                fetchByte  <= mem[ptrFetch ? fetchAddr : pc];
            end else begin
                fetchValid <= 1'b0;
                // Idle bus inverts the last byte every cycle instead of holding it
                fetchByte  <= ~fetchByte;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) pc <= START_PC;
        else if (fetchValid && fetchReq && !ptrFetch) pc <= pc + 16'h0001;
    end
endmodule

// file: verif/addressing_mode_decoder_test.sv
module addressing_mode_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import amd_pkg::*;

    logic        core_clk    = 1'b0;
    logic        rst         = 1'b1;
    logic        hold        = 1'b1;
    logic        slow        = 1'b0;
    logic        execReady   = 1'b0;
    logic [7:0]  indexFirst  = 8'hFF;
    logic [7:0]  indexSecond = 8'h81;
    logic        fetchValid, fetchReq, decodeValid, secondIndexUsed, readModifyWrite, illegalOpcode;
    logic [7:0]  fetchByte, immValue, opcodeOut;
    logic [15:0] fetchPc, fetchAddr, effAddr;
    logic [15:0] pc          = 16'h8000;
    logic [2:0]  instrLength;
    form_t       formOut;
    int          fails       = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #10 core_clk = ~core_clk;

    addressing_mode_decoder dut_u (.core_clk(core_clk), .rst(rst), .fetchValid(fetchValid),
        .fetchByte(fetchByte), .fetchPc(fetchPc), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
        .indexFirst(indexFirst), .indexSecond(indexSecond), .execReady(execReady),
        .decodeValid(decodeValid), .opcodeOut(opcodeOut), .formOut(formOut), .effAddr(effAddr),
        .immValue(immValue), .instrLength(instrLength), .secondIndexUsed(secondIndexUsed),
        .readModifyWrite(readModifyWrite), .illegalOpcode(illegalOpcode));

    fetch_memory_model #(.START_PC(16'h8000)) mem_u (.core_clk(core_clk), .rst(rst), .hold(hold),
        .slow(slow), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchValid(fetchValid),
        .fetchByte(fetchByte), .fetchPc(fetchPc));

    // =============================================================
    // Shared tasks
    task automatic print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Loads one instruction, lets it be fetched, judges and accepts it
    task automatic dec(input int n, input logic [7:0] b0, b1, b2, input form_t f, input logic [2:0] len,
                       input logic [15:0] ea, input logic sec, input logic rmw);
        logic [7:0] b [3];
        int         i;
        b = '{b0, b1, b2};
        for (i = 0; i < n; i++) mem_u.mem[pc + 16'(i)] = b[i];
        pc = pc + 16'(n);
        hold <= 1'b0;
        for (i = 0; i < 80 && decodeValid !== 1'b1; i++) @(negedge core_clk);
        hold <= 1'b1;
        check(16'(formOut), 16'(f), "form");
        check(16'(instrLength), 16'(len), "length");
        if (f == FORM_IMMEDIATE) check(16'(immValue), ea, "operand");
        else if (f != FORM_INHERENT && f != FORM_ILLEGAL) check(effAddr, ea, "address");
        check(16'(secondIndexUsed), 16'(sec), "index select");
        check(16'(opcodeOut), 16'((b0 == INDEX_SWAP_PREFIX || b0 == INDIRECTION_PREFIX) ? b1 : b0), "opcode");
        check(16'(illegalOpcode), 16'(f == FORM_ILLEGAL), "illegal flag");
        if (f != FORM_INHERENT) check(16'(readModifyWrite), 16'(rmw), "update flag");
        execReady = 1'b1;
        @(negedge core_clk);
        execReady = 1'b0;
    endtask

    // =============================================================
    // Scenarios
    task automatic t_inherent;
        logic [7:0] ops [12];
        ops = '{OP_NOP, OP_TRAP, OP_SLEEP_UNTIL_IRQ, OP_HALT, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
                OP_MASK_INTERRUPTS, OP_UNMASK_INTERRUPTS, OP_CARRY_FORCE_ONE, OP_CARRY_FORCE_ZERO,
                OP_STACK_POINTER_RELOAD, OP_BYTE_PRODUCT};
        foreach (ops[k]) dec(1, ops[k], 8'h00, 8'h00, FORM_INHERENT, 3'h1, 16'h0000, 1'b0, 1'b0);
        $display("inherent test done");
    endtask

    task automatic t_direct;
        dec(2, 8'hA6, 8'h5A, 8'h00, FORM_IMMEDIATE, 3'h2, 16'h005A, 1'b0, 1'b0);
        dec(1, 8'hA8, 8'h00, 8'h00, FORM_ILLEGAL, 3'h1, 16'h0000, 1'b0, 1'b0);
        dec(2, 8'hB6, 8'h3C, 8'h00, FORM_DIR_SHORT, 3'h2, 16'h003C, 1'b0, 1'b0);
        dec(3, 8'hC6, 8'h12, 8'h34, FORM_DIR_LONG, 3'h3, 16'h1234, 1'b0, 1'b0);
        $display("immediate and direct test done");
    endtask

    task automatic t_indexed;
        dec(1, 8'hF6, 8'h00, 8'h00, FORM_IDX_NONE, 3'h1, 16'h00FF, 1'b0, 1'b0);
        dec(2, INDEX_SWAP_PREFIX, 8'hF6, 8'h00, FORM_IDX_NONE, 3'h2, 16'h0081, 1'b1, 1'b0);
        dec(2, 8'hE6, 8'hFF, 8'h00, FORM_IDX_SHORT, 3'h2, 16'h01FE, 1'b0, 1'b0);
        dec(3, 8'hD6, 8'h12, 8'h00, FORM_IDX_LONG, 3'h3, 16'h12FF, 1'b0, 1'b0);
        $display("indexed test done");
    endtask

    task automatic t_indirect;
        slow <= 1'b1;
        mem_u.mem[16'h0040] = 8'h77;
        mem_u.mem[16'h0050] = 8'hAB;
        mem_u.mem[16'h0051] = 8'hCD;
        dec(3, INDIRECTION_PREFIX, 8'hB6, 8'h40, FORM_IND_SHORT, 3'h3, 16'h0077, 1'b0, 1'b0);
        dec(3, INDIRECTION_PREFIX, 8'hC6, 8'h50, FORM_IND_LONG, 3'h3, 16'hABCD, 1'b0, 1'b0);
        slow <= 1'b0;
        $display("indirect test done");
    endtask

    task automatic t_relative_rmw;
        dec(2, 8'h27, 8'h80, 8'h00, FORM_REL_DIRECT, 3'h2, pc + 16'h0002 - 16'h0080, 1'b0, 1'b0);
        dec(2, 8'h27, 8'h7F, 8'h00, FORM_REL_DIRECT, 3'h2, pc + 16'h0081, 1'b0, 1'b0);
        dec(2, 8'h3A, 8'h20, 8'h00, FORM_DIR_SHORT, 3'h2, 16'h0020, 1'b0, 1'b1);
        dec(2, 8'h6A, 8'h10, 8'h00, FORM_IDX_SHORT, 3'h2, 16'h010F, 1'b0, 1'b1);
        $display("relative and update test done");
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("unexpected at %0t: run too long", $time);
            print_verdict;
        end
    end

    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        t_inherent;
        t_direct;
        t_indexed;
        t_indirect;
        t_relative_rmw;
        print_verdict;
    end
endmodule
